/* rtl/tpm_pkg.sv */
// Shared constants, field layouts and types of the T1 performance monitor and BERT block.
package tpm_pkg;
    // Register byte offsets on the AHB-Lite slave.
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_CLEAR = 8'h08;
    localparam logic [7:0] A_BERT = 8'h0C;
    localparam logic [7:0] A_SEL = 8'h10;
    localparam logic [7:0] A_DATA = 8'h14;
    localparam logic [7:0] A_TOTAL = 8'h18;
    // Field positions of the clear and select words.
    localparam int CLR_ALL_BIT = 0;
    localparam int CLR_IDX_LSB = 8;
    localparam int SEL_IDX_LSB = 0;
    localparam int SEL_STAT_LSB = 8;
    localparam int FAIL_CLR_BIT = 0;
    // Statistics geometry.
    localparam int N_STATS = 7;
    localparam int HIST_DEPTH = 96;
    localparam int STAT_W = 16;
    localparam int TOT_W = 24;
    localparam logic [3:0] INTERVAL_MIN = 4'hF;
    localparam logic [15:0] STAT_MAX = 16'hFFFF;
    localparam logic [23:0] TOTAL_MAX = 24'h00270F;
    localparam logic [16:0] BERT_MAX = 17'h1869F;
    // Minute timing, derived from the 20 MHz clock.
    localparam int CLK_HZ = 20_000_000;
    localparam int MINUTE_S = 60;
    localparam int MINUTE_CYC = MINUTE_S * CLK_HZ;
    // Pattern generator and checker constants.
    localparam logic [19:0] QRSS_SEED = 20'h00001;
    localparam logic [23:0] PAT_3IN24 = 24'h888000;
    localparam logic [5:0] SYNC_LEN = 6'h20;
    localparam logic [3:0] LOSS_LEN = 4'h8;
    localparam logic [4:0] FRAMING_SLOT = 5'h00;
    // Control word, low twelve bits of the control register.
    typedef struct packed {
        logic [4:0] chan;
        logic single;
        logic [1:0] pat;
        logic run;
        logic sys_loop;
        logic net_loop;
        logic busy_out;
    } tpm_ctrl_t;
    // Status word, low sixteen bits of the status register.
    typedef struct packed {
        logic [6:0] valid;
        logic [3:0] minutes;
        logic sync;
        logic bert_on;
        logic sys_on;
        logic net_on;
        logic fail;
    } tpm_stat_t;
    // Line-side bit stream from the framer.
    typedef struct packed {
        logic bit_en;
        logic rx_bit;
        logic [4:0] slot;
    } tpm_line_t;
    // Test pattern options.
    typedef enum logic [1:0] {
        P_QRSS = 2'h0,
        P_3IN24 = 2'h1,
        P_ZERO = 2'h2,
        P_ONE = 2'h3
    } tpm_pat_t;
    // Checker states, Gray coded along idle, hunt, sync.
    typedef enum logic [1:0] {
        BT_IDLE = 2'h0,
        BT_HUNT = 2'h1,
        BT_SYNC = 2'h3
    } tpm_bst_t;
endpackage

/* rtl/tpm_top.sv */
// T1 maintenance block: interval statistics, loopbacks and bit error rate tester.
// How it works
// - Current 15-minute interval, elapsed minutes rounded 0..15.
// - Intervals timed by own free-running timer.
// - 96-interval history, index one newest, shifts.
// - Invalid history slot reads all zero.
// - Clear zeroes statistics including current interval.
// - Data-port variant clears one or all.
// - Test without busy-out rejected, failure flagged.
// - Network-side loop returns received line signal.
// - System-side loop returns payload toward network.
// - Tester generates, checks, results always readable.
// - Data-port variant tests one or all channels.
// - QRSS option emits quasi-random sequence.
// - 3-in-24 option repeats 24-bit frame.
// - All-zeroes and all-ones options exist.
// - Reading results never disturbs running test.
// - Report no sync until pattern returns.
// - Sync reported, errors counted, saturate 99999.
// - Test runs until cancelled, then stops.
// - Report count of valid history intervals.
// - 24-hour totals over valid intervals, saturate 9999.
`timescale 1ns/10ps
module tpm_top #(
    parameter int MIN_CYCLES = tpm_pkg::MINUTE_CYC,
    parameter bit DATA_PORT = 1'b1,
    parameter int DEPTH = tpm_pkg::HIST_DEPTH
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Error event pulses from the framer, one bit per statistic.
    input wire logic [tpm_pkg::N_STATS-1:0] err_evt,
    // Line bit stream and system transmit bit.
    input wire tpm_pkg::tpm_line_t line_in,
    input wire logic sys_tx_bit,
    output logic line_tx_bit,
    output logic sys_rx_bit
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    localparam logic [30:0] MIN_LAST = 31'(MIN_CYCLES - 1);
    localparam logic [30:0] MIN_HALF = 31'(MIN_CYCLES / 2);
    localparam logic [6:0] DEPTH_C = 7'(DEPTH);

    // Bus phase state and registers.
    logic wr_q, dph_rd, rd_rdy;
    logic [7:0] addr_q;
    tpm_pkg::tpm_ctrl_t ctrl;
    logic fail;
    logic [6:0] sel_idx;
    logic [2:0] sel_stat;
    // Interval timer and history bookkeeping.
    logic [30:0] min_cnt;
    logic [3:0] minutes;
    logic [6:0] wp, valid;
    logic clr_pend;
    logic [6:0] clr_idx;
    // Statistic storage, one entry per statistic.
    logic [15:0] cur_a [0:tpm_pkg::N_STATS-1];
    logic [23:0] tot_a [0:tpm_pkg::N_STATS-1];
    logic [15:0] hrd_a [0:tpm_pkg::N_STATS-1];
    logic [15:0] hclr_a [0:tpm_pkg::N_STATS-1];
    logic [15:0] hev_a [0:tpm_pkg::N_STATS-1];
    // Tester state.
    tpm_pkg::tpm_bst_t bst;
    logic run_q;
    logic [19:0] lfsr;
    logic [23:0] p24, chk;
    logic [5:0] match_cnt;
    logic [3:0] miss_cnt;
    logic [16:0] err_cnt;

    // Maps a history index (1 newest) to its storage slot.
    function automatic logic [6:0] slot_of(input logic [6:0] p, input logic [6:0] idx);
        logic [7:0] t;
        t = {1'b0, p} + {1'b0, DEPTH_C} - {1'b0, idx};
        return (t >= {1'b0, DEPTH_C}) ? 7'(t - {1'b0, DEPTH_C}) : t[6:0];
    endfunction

    // Address decode and write strobes.
    wire ap = hsel & hready & htrans[1];
    wire we_ctrl = wr_q & (addr_q == tpm_pkg::A_CTRL);
    wire we_stat = wr_q & (addr_q == tpm_pkg::A_STAT);
    wire we_clr = wr_q & (addr_q == tpm_pkg::A_CLEAR);
    wire we_sel = wr_q & (addr_q == tpm_pkg::A_SEL);
    wire tpm_pkg::tpm_ctrl_t w = tpm_pkg::tpm_ctrl_t'(hwdata[11:0]);
    wire want = w.net_loop | w.sys_loop | w.run;
    wire keep = w.busy_out & ctrl.busy_out;
    wire reject = we_ctrl & want & ~ctrl.busy_out;
    wire tpm_pkg::tpm_ctrl_t next_ctrl = {w.chan, w.single & DATA_PORT, w.pat,
        w.run & keep, w.sys_loop & keep, w.net_loop & keep, w.busy_out};
    // Clear decode; the router variant only knows clear all.
    wire [6:0] wclr_idx = hwdata[tpm_pkg::CLR_IDX_LSB +: 7];
    wire clr_all = we_clr & (hwdata[tpm_pkg::CLR_ALL_BIT] | ~DATA_PORT);
    wire clr_cur = we_clr & ~clr_all & (wclr_idx == 7'h00);
    wire clr_req = we_clr & ~clr_all & (wclr_idx != 7'h00) & (wclr_idx <= valid);

    // Interval timing.
    wire min_end = (min_cnt == MIN_LAST);
    wire roll = min_end & (minutes == tpm_pkg::INTERVAL_MIN - 4'h1);
    wire full = (valid == DEPTH_C);
    wire clr_one = clr_pend & ~roll & ~clr_all;
    wire [6:0] clr_slot = slot_of(wp, clr_idx);
    wire [6:0] rd_slot = slot_of(wp, sel_idx);
    wire [3:0] elapsed = minutes + {3'h0, min_cnt >= MIN_HALF};

    // Free-running minute and interval timer, not tied to any time of day.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            min_cnt <= '0;
            minutes <= '0;
        end else begin
            min_cnt <= min_end ? '0 : min_cnt + 31'h1;
            if (roll) begin
                minutes <= '0;
            end else if (min_end) begin
                minutes <= minutes + 4'h1;
            end
        end
    end

    // History write pointer and valid-interval count.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wp <= '0;
            valid <= '0;
        end else begin
            if (roll) begin
                wp <= (wp == DEPTH_C - 7'h1) ? '0 : wp + 7'h1;
            end
            if (clr_all) begin
                valid <= '0;
            end else if (roll & ~full) begin
                valid <= valid + 7'h1;
            end
        end
    end

    // A single-interval clear waits out a rollover cycle.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            clr_pend <= 1'b0;
            clr_idx <= '0;
        end else if (clr_req) begin
            clr_pend <= 1'b1;
            clr_idx <= wclr_idx;
        end else if (clr_one | clr_all) begin
            clr_pend <= 1'b0;
        end
    end

    // Per-statistic current counter, history column and running total.
    genvar s;
    generate
        for (s = 0; s < tpm_pkg::N_STATS; s++) begin : g_stat
            logic [15:0] h [0:DEPTH-1];
            assign hrd_a[s] = h[rd_slot];
            assign hclr_a[s] = h[clr_slot];
            assign hev_a[s] = full ? h[wp] : 16'h0000;
            // History column; storage is not reset, validity masks it.
            always_ff @(posedge mclk) begin
                if (roll) begin
                    h[wp] <= cur_a[s];
                end else if (clr_one) begin
                    h[clr_slot] <= '0;
                end
            end
            // Current counter; an event in a clear cycle still counts.
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    cur_a[s] <= '0;
                end else if (clr_all | clr_cur | roll) begin
                    cur_a[s] <= {15'h0000, err_evt[s]};
                end else if (err_evt[s] & (cur_a[s] != tpm_pkg::STAT_MAX)) begin
                    cur_a[s] <= cur_a[s] + 16'h1;
                end
            end
            // Total over valid intervals, oldest dropped as it is evicted.
            always_ff @(posedge mclk or posedge rst) begin
                if (rst | 1'b0) begin
                    tot_a[s] <= '0;
                end else if (clr_all) begin
                    tot_a[s] <= '0;
                end else if (roll) begin
                    tot_a[s] <= tot_a[s] + {8'h00, cur_a[s]} - {8'h00, hev_a[s]};
                end else if (clr_one) begin
                    tot_a[s] <= tot_a[s] - {8'h00, hclr_a[s]};
                end
            end
        end
    endgenerate

    // Selected statistic readout; slots beyond the valid count read zero.
    wire [23:0] tot_sel = tot_a[sel_stat];
    wire hist_ok = (sel_idx <= valid) & (sel_idx <= DEPTH_C);
    wire [15:0] data_mux = (sel_idx == 7'h00) ? cur_a[sel_stat] :
                           hist_ok ? hrd_a[sel_stat] : 16'h0000;
    wire [15:0] tot_sat = (tot_sel >= tpm_pkg::TOTAL_MAX) ?
                          tpm_pkg::TOTAL_MAX[15:0] : tot_sel[15:0];

    // Control, failure flag and select registers.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl <= '0;
            fail <= 1'b0;
            sel_idx <= '0;
            sel_stat <= '0;
        end else begin
            if (we_ctrl) begin
                ctrl <= next_ctrl;
            end
            if (reject) begin
                fail <= 1'b1;
            end else if (we_stat & hwdata[tpm_pkg::FAIL_CLR_BIT]) begin
                fail <= 1'b0;
            end
            if (we_sel) begin
                sel_idx <= hwdata[tpm_pkg::SEL_IDX_LSB +: 7];
                sel_stat <= (hwdata[tpm_pkg::SEL_STAT_LSB +: 3] > 3'h6) ? 3'h0 :
                            hwdata[tpm_pkg::SEL_STAT_LSB +: 3];
            end
        end
    end

    // Tester bit qualification: all payload slots or one chosen slot.
    wire payload = line_in.slot != tpm_pkg::FRAMING_SLOT;
    wire act = line_in.bit_en & ctrl.run & payload &
               (~ctrl.single | (line_in.slot == ctrl.chan));
    wire start = ctrl.run & ~run_q;
    // Generator output by option.
    wire gen_bit = (ctrl.pat == tpm_pkg::P_QRSS) ? lfsr[19] :
                   (ctrl.pat == tpm_pkg::P_3IN24) ? p24[23] :
                   (ctrl.pat == tpm_pkg::P_ONE);
    // Checker prediction from previously received bits.
    wire pred = (ctrl.pat == tpm_pkg::P_QRSS) ? (chk[19] ^ chk[16]) :
                (ctrl.pat == tpm_pkg::P_3IN24) ? chk[23] :
                (ctrl.pat == tpm_pkg::P_ONE);
    wire miss = line_in.rx_bit != pred;

    // Pattern generator; restarts from its seed on each new test.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            run_q <= 1'b0;
            lfsr <= tpm_pkg::QRSS_SEED;
            p24 <= tpm_pkg::PAT_3IN24;
            chk <= '0;
        end else begin
            run_q <= ctrl.run;
            if (start) begin
                lfsr <= tpm_pkg::QRSS_SEED;
                p24 <= tpm_pkg::PAT_3IN24;
            end else if (act) begin
                lfsr <= {lfsr[18:0], lfsr[19] ^ lfsr[16]};
                p24 <= {p24[22:0], p24[23]};
                chk <= {chk[22:0], line_in.rx_bit};
            end
        end
    end

    // Checker sync machine: hunt for a clean run, lose sync on a miss burst.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bst <= tpm_pkg::BT_IDLE;
            match_cnt <= '0;
            miss_cnt <= '0;
        end else if (~ctrl.run | start) begin
            bst <= ctrl.run ? tpm_pkg::BT_HUNT : tpm_pkg::BT_IDLE;
            match_cnt <= '0;
            miss_cnt <= '0;
        end else if (act) begin
            case (bst)
                tpm_pkg::BT_HUNT: begin
                    match_cnt <= miss ? '0 : match_cnt + 6'h1;
                    if (~miss & (match_cnt == tpm_pkg::SYNC_LEN - 6'h1)) begin
                        bst <= tpm_pkg::BT_SYNC;
                    end
                end
                tpm_pkg::BT_SYNC: begin
                    miss_cnt <= miss ? miss_cnt + 4'h1 : '0;
                    if (miss & (miss_cnt == tpm_pkg::LOSS_LEN - 4'h1)) begin
                        bst <= tpm_pkg::BT_HUNT;
                        match_cnt <= '0;
                    end
                end
                default: begin
                    bst <= tpm_pkg::BT_HUNT;
                end
            endcase
        end
    end

    // Bit error counter: only in sync, saturating, cleared on start.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            err_cnt <= '0;
        end else if (start) begin
            err_cnt <= '0;
        end else if (act & miss & (bst == tpm_pkg::BT_SYNC) & (err_cnt != tpm_pkg::BERT_MAX)) begin
            err_cnt <= err_cnt + 17'h1;
        end
    end

    // Line transmit selection: network loop, system loop, tester, normal.
    wire next_tx = ctrl.net_loop ? line_in.rx_bit :
                   ctrl.sys_loop ? (payload ? line_in.rx_bit : sys_tx_bit) :
                   act ? gen_bit : sys_tx_bit;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            line_tx_bit <= 1'b0;
            sys_rx_bit <= 1'b0;
        end else if (line_in.bit_en) begin
            line_tx_bit <= next_tx;
            sys_rx_bit <= line_in.rx_bit;
        end
    end

    // Status word and read multiplexer; reads have no side effect.
    wire tpm_pkg::tpm_stat_t stat = {valid, elapsed, bst == tpm_pkg::BT_SYNC,
        ctrl.run, ctrl.sys_loop, ctrl.net_loop, fail};
    wire [31:0] rd_mux =
        (addr_q == tpm_pkg::A_CTRL) ? {20'h00000, ctrl} :
        (addr_q == tpm_pkg::A_STAT) ? {16'h0000, stat} :
        (addr_q == tpm_pkg::A_BERT) ? {15'h0000, err_cnt} :
        (addr_q == tpm_pkg::A_SEL) ? {21'h000000, sel_stat, 1'b0, sel_idx} :
        (addr_q == tpm_pkg::A_DATA) ? {16'h0000, data_mux} :
        (addr_q == tpm_pkg::A_TOTAL) ? {16'h0000, tot_sat} : 32'h00000000;

    // Bus phases: writes complete at once, reads take one wait state.
    assign hreadyout = ~(dph_rd & ~rd_rdy);
    assign hresp = 1'b0;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_q <= 1'b0;
            dph_rd <= 1'b0;
            rd_rdy <= 1'b0;
            addr_q <= '0;
            hrdata <= '0;
        end else begin
            rd_rdy <= dph_rd & ~rd_rdy;
            if (hready) begin
                wr_q <= ap & hwrite;
                dph_rd <= ap & ~hwrite;
            end
            if (ap) begin
                addr_q <= haddr[7:0];
            end
            if (dph_rd & ~rd_rdy) begin
                hrdata <= rd_mux;
            end
        end
    end

    // Checks on the behaviour above.
    a_test_reject: assert property (reject |=> fail && !ctrl.run && !ctrl.net_loop)
        else $error("test accepted while in service");
    a_interval_roll: assert property (roll && !full && !clr_all |=> valid == $past(valid) + 7'h1 && minutes == 4'h0)
        else $error("interval rollover did not shift history");
    a_elapsed_max: assert property (elapsed <= tpm_pkg::INTERVAL_MIN)
        else $error("elapsed minutes out of range");
    a_bert_sat: assert property (err_cnt == tpm_pkg::BERT_MAX && !start |=> err_cnt == tpm_pkg::BERT_MAX)
        else $error("error count left saturation");
    a_err_nosync: assert property (bst != tpm_pkg::BT_SYNC && !start |=> $stable(err_cnt))
        else $error("errors counted out of sync");
    a_stop_idle: assert property (!ctrl.run |=> bst == tpm_pkg::BT_IDLE)
        else $error("checker active after cancel");
    a_net_loop: assert property (line_in.bit_en && ctrl.net_loop |=> line_tx_bit == $past(line_in.rx_bit))
        else $error("network loop not returning line");
    a_hist_zero: assert property (sel_idx != 7'h00 && sel_idx > valid |-> data_mux == 16'h0000)
        else $error("invalid slot read nonzero");
    a_total_sat: assert property (tot_sel >= tpm_pkg::TOTAL_MAX |-> tot_sat == 16'h270F)
        else $error("total not saturated");
    a_clear_cur: assert property (clr_all |=> cur_a[0] == {15'h0000, $past(err_evt[0])})
        else $error("clear did not zero current");
    a_read_wait: assert property (ap && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    c_sync: cover property (bst == tpm_pkg::BT_HUNT ##1 bst == tpm_pkg::BT_SYNC);
    c_roll: cover property (roll);
    c_reject: cover property (reject);
    c_one_clear: cover property (clr_one);
endmodule

/* verification/tpm_far_end.sv */
// Far-end T1 line model: a framed bit source that can loop the device's bits back.
`timescale 1ns/10ps
module tpm_far_end (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Bench controls.
    input wire logic loop_back,
    input wire logic flip,
    // Line toward and from the device.
    input wire logic line_tx_bit,
    output tpm_pkg::tpm_line_t line_in
);
    logic [1:0] div; // Four clocks per line bit.
    logic [7:0] bitc; // Bit position in the 193-bit frame.
    logic flip_pend; // One payload bit still to be inverted.
    logic frame_mem [193]; // One frame of delay keeps the slots aligned.
    integer seed = 32'ha49e; // Fixed seed for repeatable traffic.
    integer rnd; // Random draw of this clock.
    wire logic [7:0] slot_w = (bitc == 8'h00) ? 8'h00 : ((bitc - 8'h01) >> 3) + 8'h01;
    wire logic [7:0] prev_w = (bitc == 8'h00) ? 8'hC0 : bitc - 8'h01;
    // The delay line starts quiet so no unknown reaches the device.
    initial foreach (frame_mem[i]) frame_mem[i] = 1'b0;
    // Emit one bit every fourth clock; the far end sources it or loops it.
    always @(posedge mclk or posedge rst) begin
        rnd = $random(seed);
        if (rst) begin
            div <= 2'h0;
            bitc <= 8'h00;
            flip_pend <= 1'b0;
            line_in <= '0;
        end else begin
            div <= div + 2'h1;
            line_in.bit_en <= (div == 2'h3);
            if (div == 2'h3) begin
                bitc <= (bitc == 8'hC0) ? 8'h00 : bitc + 8'h01;
                line_in.slot <= slot_w[4:0];
                frame_mem[prev_w] <= line_tx_bit;
                line_in.rx_bit <= loop_back ? frame_mem[bitc] ^ flip_pend : rnd[0];
            end
            flip_pend <= (div == 2'h3 && slot_w != 8'h00) ? flip : flip_pend | flip;
        end
    end
endmodule

/* verification/tb_t1_perf_monitor_bert.sv */
// Self-checking bench of the T1 maintenance block against a far-end line model.
`timescale 1ns/10ps
module tb_t1_perf_monitor_bert;
    logic mclk = 1'b0; // 20 MHz clock.
    logic rst = 1'b1; // Reset, held for three cycles.
    logic hsel = 1'b0; // Bus master signals.
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp;
    logic [31:0] hrdata;
    logic [6:0] err_evt = 7'h00; // Error events toward the design.
    tpm_pkg::tpm_line_t line_in; // Line stream from the far end.
    logic sys_tx_bit = 1'b0; // System transmit bit.
    logic line_tx_bit, sys_rx_bit;
    logic loop_back = 1'b0; // Far end loops the line back.
    logic flip = 1'b0; // Inverts one looped bit.
    logic evt_on = 1'b0; // Enables random error events.
    logic [31:0] rd; // Last read data.
    integer seed = 32'ha49e;
    integer rv;
    integer mismatches = 0;
    integer n_tests = 0;
    integer cnt [7] = '{default: 0}; // Events sampled per statistic.
    tpm_top #(.MIN_CYCLES(20), .DATA_PORT(1'b1), .DEPTH(96)) DUT (
        .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .err_evt(err_evt),
        .line_in(line_in), .sys_tx_bit(sys_tx_bit), .line_tx_bit(line_tx_bit),
        .sys_rx_bit(sys_rx_bit));
    tpm_far_end far (.mclk(mclk), .rst(rst), .loop_back(loop_back), .flip(flip),
        .line_tx_bit(line_tx_bit), .line_in(line_in));
    // Clock of 50 ns period.
    always #25 mclk = ~mclk;
    // Random events and system bits, counted as sampled.
    always @(posedge mclk) begin
        rv = $random(seed);
        for (int i = 0; i < 7; i++) begin
            cnt[i] = cnt[i] + err_evt[i];
        end
        err_evt <= evt_on ? rv[6:0] : 7'h00;
        sys_tx_bit <= rv[8];
    end
    // Compare one value and count the outcome.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Print the counts and the verdict, then stop.
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Bounded wait for hready high at an edge.
    task automatic wait_ready();
        int k;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1) begin
            mismatches++;
            close_out();
        end
    endtask
    // One single-word AHB-Lite transfer; read data lands in rd.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        chk(hresp, 1'b0);
    endtask
    // Read status until the masked field matches, bounded.
    task automatic poll(input logic [31:0] m, input logic [31:0] v);
        int k;
        k = 0;
        do begin
            xfer(1'b0, tpm_pkg::A_STAT, 32'h0);
            k++;
        end while ((rd & m) !== v && k < 600);
        chk(rd & m, v);
        if ((rd & m) !== v) begin
            close_out();
        end
    endtask
    // Bit expected toward the network for each line mode.
    function automatic logic exp_tx(int kind, logic rx, logic sx, logic [4:0] sl);
        case (kind)
            0: return rx;
            1: return (sl == 5'h00) ? sx : rx;
            2: return (sl == 5'h05) ? 1'b1 : sx;
            default: return (sl == 5'h00) ? sx : 1'b0;
        endcase
    endfunction
    // Check the transmitted bit one edge after each line bit.
    task automatic line_chk(input int kind, input int nbits);
        logic rx;
        logic sx;
        logic [4:0] sl;
        for (int n = 0; n < nbits; n++) begin
            @(posedge mclk);
            for (int k = 0; k < 8 && line_in.bit_en !== 1'b1; k++) @(posedge mclk);
            rx = line_in.rx_bit;
            sx = sys_tx_bit;
            sl = line_in.slot;
            @(posedge mclk);
            chk(line_tx_bit, exp_tx(kind, rx, sx, sl));
            chk(sys_rx_bit, rx);
        end
    endtask
    // Hang guard.
    initial begin
        repeat (100000) @(posedge mclk);
        mismatches++;
        close_out();
    end
    // Main sequence.
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        xfer(1'b0, tpm_pkg::A_CTRL, 0);
        chk(rd, 32'h0);
        xfer(1'b1, 8'hFC, 32'hFFFFFFFF);
        xfer(1'b0, 8'hFC, 0);
        chk(rd, 32'h0);
        // A loop asked for while in service is refused and flagged.
        xfer(1'b1, tpm_pkg::A_CTRL, 32'h2);
        xfer(1'b0, tpm_pkg::A_CTRL, 0);
        chk(rd, 32'h0);
        xfer(1'b0, tpm_pkg::A_STAT, 0);
        chk(rd[1:0], 2'h1);
        xfer(1'b1, tpm_pkg::A_STAT, 32'h1);
        xfer(1'b0, tpm_pkg::A_STAT, 0);
        chk(rd[0], 1'b0);
        // Busied out: both loops, then single-channel ones and all-channel zeroes.
        xfer(1'b1, tpm_pkg::A_CTRL, 32'h1);
        xfer(1'b1, tpm_pkg::A_CTRL, 32'h3);
        xfer(1'b0, tpm_pkg::A_STAT, 0);
        chk(rd[1], 1'b1);
        line_chk(0, 60);
        xfer(1'b1, tpm_pkg::A_CTRL, 32'h5);
        line_chk(1, 60);
        xfer(1'b1, tpm_pkg::A_CTRL, 32'h2F9);
        line_chk(2, 400);
        xfer(1'b1, tpm_pkg::A_CTRL, 32'h29);
        line_chk(3, 60);
        // Every pattern reaches sync when the far end loops it back.
        loop_back <= 1'b1;
        for (int p = 0; p < 4; p++) begin
            xfer(1'b1, tpm_pkg::A_CTRL, 32'h1);
            xfer(1'b1, tpm_pkg::A_CTRL, 32'h9 | (p << 4));
            poll(32'h10, 32'h10);
        end
        xfer(1'b0, tpm_pkg::A_BERT, 0);
        chk(rd, 32'h0);
        flip <= 1'b1;
        @(posedge mclk);
        flip <= 1'b0;
        repeat (200) @(posedge mclk);
        xfer(1'b0, tpm_pkg::A_BERT, 0);
        chk(rd, 32'h1);
        xfer(1'b0, tpm_pkg::A_STAT, 0);
        chk(rd[4:3], 2'h3);
        xfer(1'b0, tpm_pkg::A_BERT, 0);
        chk(rd, 32'h1);
        xfer(1'b1, tpm_pkg::A_CTRL, 32'h1);
        xfer(1'b0, tpm_pkg::A_STAT, 0);
        chk(rd[4:3], 2'h0);
        // Random line, no loop: never sync, count cleared at start.
        loop_back <= 1'b0;
        xfer(1'b1, tpm_pkg::A_CTRL, 32'h39);
        xfer(1'b0, tpm_pkg::A_BERT, 0);
        chk(rd, 32'h0);
        repeat (600) @(posedge mclk);
        xfer(1'b0, tpm_pkg::A_STAT, 0);
        chk(rd[4:3], 2'h1);
        xfer(1'b0, tpm_pkg::A_BERT, 0);
        chk(rd, 32'h0);
        xfer(1'b1, tpm_pkg::A_CTRL, 32'h0);
        // Intervals: clear, align to a boundary, then count random events.
        xfer(1'b1, tpm_pkg::A_CLEAR, 32'h1);
        xfer(1'b0, tpm_pkg::A_STAT, 0);
        chk(rd[15:9], 7'h00);
        poll(32'hFE00, 32'h0200);
        cnt = '{default: 0};
        evt_on <= 1'b1;
        repeat (40) @(posedge mclk);
        evt_on <= 1'b0;
        repeat (2) @(posedge mclk);
        for (int s = 0; s < 7; s++) begin
            xfer(1'b1, tpm_pkg::A_SEL, s << 8);
            xfer(1'b0, tpm_pkg::A_DATA, 0);
            chk(rd, cnt[s]);
        end
        poll(32'hFE00, 32'h0400);
        chk(rd[8:5], 4'h0);
        for (int s = 0; s < 7; s++) begin
            xfer(1'b1, tpm_pkg::A_SEL, (s << 8) | 1);
            xfer(1'b0, tpm_pkg::A_DATA, 0);
            chk(rd, cnt[s]);
            xfer(1'b0, tpm_pkg::A_TOTAL, 0);
            chk(rd, cnt[s]);
        end
        xfer(1'b1, tpm_pkg::A_SEL, 32'h3);
        xfer(1'b0, tpm_pkg::A_DATA, 0);
        chk(rd, 32'h0);
        xfer(1'b1, tpm_pkg::A_CLEAR, 32'h100);
        xfer(1'b1, tpm_pkg::A_SEL, 32'h1);
        xfer(1'b0, tpm_pkg::A_DATA, 0);
        chk(rd, 32'h0);
        xfer(1'b0, tpm_pkg::A_TOTAL, 0);
        chk(rd, 32'h0);
        xfer(1'b0, tpm_pkg::A_STAT, 0);
        chk(rd[15:9], 7'h02);
        xfer(1'b1, tpm_pkg::A_CLEAR, 32'h1);
        xfer(1'b0, tpm_pkg::A_STAT, 0);
        chk(rd[15:9], 7'h00);
        close_out();
    end
endmodule
